// ===== verilog/pmc_pkg.sv
// Package: command codes, encodings, limits and reset values
`default_nettype none
package pmc_pkg;

  // Command codes seen on the command port
  localparam logic [7:0] PMC_CMD_OPERATION = 8'h01;
  localparam logic [7:0] PMC_CMD_ON_OFF_CFG = 8'h02;
  localparam logic [7:0] PMC_CMD_STORE_DEFAULTS = 8'h11;
  localparam logic [7:0] PMC_CMD_VOUT_SET = 8'h21;
  localparam logic [7:0] PMC_CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] PMC_CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] PMC_CMD_INP_ON_TH = 8'h35;
  localparam logic [7:0] PMC_CMD_INP_OFF_TH = 8'h36;
  localparam logic [7:0] PMC_CMD_START_DLY = 8'h60;
  localparam logic [7:0] PMC_CMD_RAMP_TIME = 8'h61;
  localparam logic [7:0] PMC_CMD_MEAS_INP_V = 8'h88;
  localparam logic [7:0] PMC_CMD_MEAS_OUT_V = 8'h8B;
  localparam logic [7:0] PMC_CMD_MEAS_OUT_I = 8'h8C;
  localparam logic [7:0] PMC_CMD_VOUT_OFS_TRIM = 8'hD4;
  localparam logic [7:0] PMC_CMD_VIN_OFS_TRIM = 8'hD5;
  localparam logic [7:0] PMC_CMD_VIN_GAIN_TRIM = 8'hD6;
  localparam logic [7:0] PMC_CMD_IOUT_OFS_TRIM = 8'hD7;
  localparam logic [7:0] PMC_CMD_IOUT_GAIN_TRIM = 8'hD8;

  // Linear word fields
  localparam int PMC_EXP_MSB = 15;
  localparam int PMC_EXP_LSB = 11;
  localparam int PMC_MANT_SIGN = 10;
  localparam logic [4:0] PMC_EXP_M1 = 5'h1F;
  localparam logic [4:0] PMC_EXP_M3 = 5'h1D;
  localparam logic [4:0] PMC_EXP_M4 = 5'h1C;

  // Legal ranges in mantissa units
  localparam logic [10:0] PMC_VIN_MIN = 11'h100;
  localparam logic [10:0] PMC_VIN_MAX = 11'h170;
  localparam logic [10:0] PMC_DELAY_MIN = 11'h014;
  localparam logic [10:0] PMC_RISE_MIN = 11'h01E;
  localparam logic [10:0] PMC_TIME_MAX = 11'h3E8;
  localparam logic [15:0] PMC_VOUT_MIN = 16'h819A;
  localparam logic [15:0] PMC_VOUT_MAX = 16'hD333;
  localparam logic [10:0] PMC_IOUT_BLANK = 11'h01B;
  localparam logic [10:0] PMC_MANT_MAX = 11'h3FF;
  localparam int PMC_GAIN_SHIFT = 13;

  // Operation byte fields and margin codes
  localparam int PMC_OP_ON = 7;
  localparam int PMC_OP_MRG_MSB = 5;
  localparam int PMC_OP_MRG_LSB = 2;
  localparam logic [1:0] PMC_MRG_OFF_HI = 2'h0;
  localparam logic [3:0] PMC_MRG_LOW = 4'h6;
  localparam logic [3:0] PMC_MRG_HIGH = 4'hA;

  // Reset values
  localparam logic [7:0] PMC_OP_RESET = 8'h80;
  localparam logic [1:0] PMC_CFG_RESET = 2'h3;
  localparam int PMC_IMG_W = 112;

  typedef enum logic [0:0] {
    PMC_ST_LOAD = 1'b0,
    PMC_ST_RUN = 1'b1
  } pmc_state_t;

endpackage : pmc_pkg

`default_nettype wire

// ===== verilog/pmc_cmd_core.sv
// Command-value logic of the power module management interface
//
// Overview of operation
// - Output-voltage words: unsigned mantissa, exponent minus twelve
// - Other words: 5-bit exponent, 11-bit mantissa
// - Operation bit 7 enables the output
// - On/off config: bits 3,2 writable, bits 4,1,0 ones, rest zeros
// - Command-response bit gates operation enable bit
// - Power-up mode needs pin and operation
// - Pin-required bit needs on/off pin asserted
// - Input thresholds 32 to 46 V, 0.125 steps
// - Input thresholds: exponent minus three, sign zero
// - Turn-on delay 10 to 500 ms
// - Rise time 15 to 500 ms
// - Time words: exponent minus one, sign zero
// - Set point 8.10 to 13.20 V
// - Operation bits 5:2 select margin state
// - Margin values used only when margining selected
// - Store command copies settings to non-volatile image
// - Output voltage read adds signed offset trim
// - Input voltage read: gain/8192 plus offset
// - Current read exponent minus four, 1.6875 A blanking
// - Sinking current reads as zero
// - Current read: gain/8192 plus offset
`timescale 1ns/10ps
`default_nettype none

module pmc_cmd_core #(
  parameter logic signed [15:0] VOUT_OFFSET_TRIM = 16'h0000,
  parameter logic signed [10:0] VIN_OFFSET_TRIM = 11'h000,
  parameter logic [15:0] VIN_GAIN_TRIM = 16'h2000,
  parameter logic signed [10:0] IOUT_OFFSET_TRIM = 11'h000,
  parameter logic [15:0] IOUT_GAIN_TRIM = 16'h2000
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [7:0] req_code_i,
  input wire logic [15:0] req_wdata_i,
  output logic resp_valid_o,
  output logic [15:0] resp_rdata_o,
  output logic resp_bad_cmd_o,
  output logic resp_bad_data_o,
  input wire logic onoff_pin_i,
  input wire logic [15:0] vout_adc_i,
  input wire logic [10:0] vin_adc_i,
  input wire logic signed [10:0] iout_adc_i,
  input wire logic [pmc_pkg::PMC_IMG_W-1:0] nvm_image_i,
  output logic nvm_store_o,
  output logic [pmc_pkg::PMC_IMG_W-1:0] nvm_image_o,
  output logic output_enable_o,
  output logic [15:0] vout_target_o
);
  import pmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    pmc_state_t st;
    logic [7:0] op;
    logic [1:0] cfg;
    logic [15:0] thr_on;
    logic [15:0] thr_off;
    logic [15:0] start_dly;
    logic [15:0] ramp_time;
    logic [15:0] vout_set;
    logic [15:0] mrg_high;
    logic [15:0] mrg_low;
    logic resp_valid;
    logic [15:0] resp_data;
    logic bad_cmd;
    logic bad_data;
    logic store;
    logic [PMC_IMG_W-1:0] image;
    logic out_en;
    logic [15:0] target;
    logic [15:0] rd_vout;
    logic [15:0] rd_vin;
    logic [15:0] rd_iout;
  } pmc_core_t;

  pmc_core_t s_r;
  pmc_core_t s_nxt;

  function automatic logic pmc_lin_ok(input logic [15:0] w,
                                      input logic [4:0] e,
                                      input logic [10:0] lo,
                                      input logic [10:0] hi);
    logic ok;
    ok = (w[PMC_EXP_MSB:PMC_EXP_LSB] == e) && !w[PMC_MANT_SIGN];
    ok = ok && (w[10:0] >= lo) && (w[10:0] <= hi);
    return ok;
  endfunction : pmc_lin_ok

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [PMC_IMG_W-1:0] img;
    logic cmd_ok;
    logic pin_ok;
    logic signed [17:0] vout_sum;
    logic [26:0] vin_prod;
    logic signed [15:0] vin_sum;
    logic [26:0] iout_prod;
    logic signed [15:0] iout_sum;
    logic [10:0] iout_m;
    logic wr;
    logic rd;
    logic [3:0] mrg;
    img = '0;
    cmd_ok = 1'b0;
    pin_ok = 1'b0;
    vout_sum = '0;
    vin_prod = '0;
    vin_sum = '0;
    iout_prod = '0;
    iout_sum = '0;
    iout_m = '0;
    mrg = req_wdata_i[PMC_OP_MRG_MSB:PMC_OP_MRG_LSB];
    wr = req_valid_i && req_write_i && (s_r.st == PMC_ST_RUN);
    rd = req_valid_i && !req_write_i && (s_r.st == PMC_ST_RUN);
    s_nxt = s_r;
    s_nxt.resp_valid = 1'b0;
    s_nxt.bad_cmd = 1'b0;
    s_nxt.bad_data = 1'b0;
    s_nxt.store = 1'b0;

    unique case (s_r.st)
      PMC_ST_LOAD: begin
        // Stored defaults taken once after reset release
        s_nxt.thr_on = nvm_image_i[111:96];
        s_nxt.thr_off = nvm_image_i[95:80];
        s_nxt.start_dly = nvm_image_i[79:64];
        s_nxt.ramp_time = nvm_image_i[63:48];
        s_nxt.vout_set = nvm_image_i[47:32];
        s_nxt.mrg_high = nvm_image_i[31:16];
        s_nxt.mrg_low = nvm_image_i[15:0];
        s_nxt.st = PMC_ST_RUN;
      end
      PMC_ST_RUN: begin
        s_nxt.st = PMC_ST_RUN;
      end
    endcase

    if (wr) begin
      s_nxt.resp_valid = 1'b1;
      s_nxt.resp_data = '0;
      unique case (req_code_i)
        PMC_CMD_OPERATION: begin
          if (mrg[3:2] == PMC_MRG_OFF_HI || mrg == PMC_MRG_LOW ||
              mrg == PMC_MRG_HIGH) begin
            s_nxt.op = req_wdata_i[7:0];
          end else begin
            s_nxt.bad_data = 1'b1;
          end
        end
        PMC_CMD_ON_OFF_CFG: s_nxt.cfg = req_wdata_i[3:2];
        PMC_CMD_INP_ON_TH: begin
          if (pmc_lin_ok(req_wdata_i, PMC_EXP_M3, PMC_VIN_MIN, PMC_VIN_MAX))
            s_nxt.thr_on = req_wdata_i;
          else
            s_nxt.bad_data = 1'b1;
        end
        PMC_CMD_INP_OFF_TH: begin
          if (pmc_lin_ok(req_wdata_i, PMC_EXP_M3, PMC_VIN_MIN, PMC_VIN_MAX))
            s_nxt.thr_off = req_wdata_i;
          else
            s_nxt.bad_data = 1'b1;
        end
        PMC_CMD_START_DLY: begin
          if (pmc_lin_ok(req_wdata_i, PMC_EXP_M1, PMC_DELAY_MIN,
                         PMC_TIME_MAX))
            s_nxt.start_dly = req_wdata_i;
          else
            s_nxt.bad_data = 1'b1;
        end
        PMC_CMD_RAMP_TIME: begin
          if (pmc_lin_ok(req_wdata_i, PMC_EXP_M1, PMC_RISE_MIN,
                         PMC_TIME_MAX))
            s_nxt.ramp_time = req_wdata_i;
          else
            s_nxt.bad_data = 1'b1;
        end
        PMC_CMD_VOUT_SET, PMC_CMD_MARGIN_HIGH, PMC_CMD_MARGIN_LOW: begin
          if (req_wdata_i < PMC_VOUT_MIN || req_wdata_i > PMC_VOUT_MAX)
            s_nxt.bad_data = 1'b1;
          else if (req_code_i == PMC_CMD_VOUT_SET)
            s_nxt.vout_set = req_wdata_i;
          else if (req_code_i == PMC_CMD_MARGIN_HIGH)
            s_nxt.mrg_high = req_wdata_i;
          else
            s_nxt.mrg_low = req_wdata_i;
        end
        PMC_CMD_STORE_DEFAULTS: begin
          s_nxt.store = 1'b1;
          s_nxt.image = {s_r.thr_on, s_r.thr_off, s_r.start_dly,
                         s_r.ramp_time, s_r.vout_set, s_r.mrg_high,
                         s_r.mrg_low};
        end
        default: s_nxt.bad_cmd = 1'b1;
      endcase
    end else if (rd) begin
      s_nxt.resp_valid = 1'b1;
      unique case (req_code_i)
        PMC_CMD_OPERATION: s_nxt.resp_data = {8'h00, s_r.op};
        PMC_CMD_ON_OFF_CFG:
          s_nxt.resp_data = {11'h000, 1'b1, s_r.cfg, 2'h3};
        PMC_CMD_INP_ON_TH: s_nxt.resp_data = s_r.thr_on;
        PMC_CMD_INP_OFF_TH: s_nxt.resp_data = s_r.thr_off;
        PMC_CMD_START_DLY: s_nxt.resp_data = s_r.start_dly;
        PMC_CMD_RAMP_TIME: s_nxt.resp_data = s_r.ramp_time;
        PMC_CMD_VOUT_SET: s_nxt.resp_data = s_r.vout_set;
        PMC_CMD_MARGIN_HIGH: s_nxt.resp_data = s_r.mrg_high;
        PMC_CMD_MARGIN_LOW: s_nxt.resp_data = s_r.mrg_low;
        PMC_CMD_MEAS_OUT_V: s_nxt.resp_data = s_r.rd_vout;
        PMC_CMD_MEAS_INP_V: s_nxt.resp_data = s_r.rd_vin;
        PMC_CMD_MEAS_OUT_I: s_nxt.resp_data = s_r.rd_iout;
        PMC_CMD_VOUT_OFS_TRIM: s_nxt.resp_data = VOUT_OFFSET_TRIM;
        PMC_CMD_VIN_OFS_TRIM:
          s_nxt.resp_data = {PMC_EXP_M3, VIN_OFFSET_TRIM};
        PMC_CMD_VIN_GAIN_TRIM: s_nxt.resp_data = VIN_GAIN_TRIM;
        PMC_CMD_IOUT_OFS_TRIM:
          s_nxt.resp_data = {PMC_EXP_M4, IOUT_OFFSET_TRIM};
        PMC_CMD_IOUT_GAIN_TRIM: s_nxt.resp_data = IOUT_GAIN_TRIM;
        default: begin
          s_nxt.resp_data = '0;
          s_nxt.bad_cmd = 1'b1;
        end
      endcase
    end

    // Start permission from pin and operation byte
    cmd_ok = !s_r.cfg[1] || s_r.op[PMC_OP_ON];
    pin_ok = !s_r.cfg[0] || onoff_pin_i;
    s_nxt.out_en = (s_r.st == PMC_ST_RUN) && cmd_ok && pin_ok;

    // Voltage target follows margin selection
    if (s_r.op[PMC_OP_MRG_MSB:PMC_OP_MRG_LSB] == PMC_MRG_HIGH)
      s_nxt.target = s_r.mrg_high;
    else if (s_r.op[PMC_OP_MRG_MSB:PMC_OP_MRG_LSB] == PMC_MRG_LOW)
      s_nxt.target = s_r.mrg_low;
    else
      s_nxt.target = s_r.vout_set;

    // Output voltage readback
    vout_sum = $signed({2'b00, vout_adc_i}) + 18'(VOUT_OFFSET_TRIM);
    if (vout_sum < 0)
      s_nxt.rd_vout = 16'h0000;
    else if (vout_sum > $signed({2'b00, 16'hFFFF}))
      s_nxt.rd_vout = 16'hFFFF;
    else
      s_nxt.rd_vout = vout_sum[15:0];

    // Input voltage readback
    vin_prod = 27'(vin_adc_i) * 27'(VIN_GAIN_TRIM);
    vin_sum = $signed({2'b00, vin_prod[26:PMC_GAIN_SHIFT]}) +
              16'(VIN_OFFSET_TRIM);
    if (vin_sum < 0)
      s_nxt.rd_vin = {PMC_EXP_M3, 11'h000};
    else if (vin_sum > $signed({5'h00, PMC_MANT_MAX}))
      s_nxt.rd_vin = {PMC_EXP_M3, PMC_MANT_MAX};
    else
      s_nxt.rd_vin = {PMC_EXP_M3, vin_sum[10:0]};

    // Output current readback
    iout_prod = 27'(iout_adc_i[9:0]) * 27'(IOUT_GAIN_TRIM);
    iout_sum = $signed({2'b00, iout_prod[26:PMC_GAIN_SHIFT]}) +
               16'(IOUT_OFFSET_TRIM);
    if (iout_adc_i[PMC_MANT_SIGN] || iout_sum < 0)
      iout_m = 11'h000;
    else if (iout_sum > $signed({5'h00, PMC_MANT_MAX}))
      iout_m = PMC_MANT_MAX;
    else
      iout_m = iout_sum[10:0];
    if (iout_m < PMC_IOUT_BLANK)
      iout_m = 11'h000;
    s_nxt.rd_iout = {PMC_EXP_M4, iout_m};
    img = s_nxt.image;
    s_nxt.image = img;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
      s_r.st <= PMC_ST_LOAD;
      s_r.op <= PMC_OP_RESET;
      s_r.cfg <= PMC_CFG_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign resp_valid_o = s_r.resp_valid;
  assign resp_rdata_o = s_r.resp_data;
  assign resp_bad_cmd_o = s_r.bad_cmd;
  assign resp_bad_data_o = s_r.bad_data;
  assign nvm_store_o = s_r.store;
  assign nvm_image_o = s_r.image;
  assign output_enable_o = s_r.out_en;
  assign vout_target_o = s_r.target;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence seq_thr_on_bad;
    req_valid_i && req_write_i && s_r.st == PMC_ST_RUN &&
    req_code_i == PMC_CMD_INP_ON_TH && req_wdata_i[10:0] > PMC_VIN_MAX;
  endsequence

  sequence seq_store_req;
    req_valid_i && req_write_i && s_r.st == PMC_ST_RUN &&
    req_code_i == PMC_CMD_STORE_DEFAULTS;
  endsequence

  AST_OP_OFF_DISABLES: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    s_r.cfg[1] && !s_r.op[PMC_OP_ON] |=> !output_enable_o)
    else $error("output enabled with operation off");

  AST_CMD_IGNORED: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    s_r.st == PMC_ST_RUN && !s_r.cfg[1] && onoff_pin_i |=> output_enable_o)
    else $error("operation bit not ignored");

  AST_PIN_REQUIRED: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    s_r.cfg[0] && !onoff_pin_i |=> !output_enable_o)
    else $error("started without on/off pin");

  AST_VIN_REJECT: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    seq_thr_on_bad |=> resp_bad_data_o && $stable(s_r.thr_on))
    else $error("bad input threshold accepted");

  AST_VOUT_RANGE: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    s_r.st == PMC_ST_RUN && s_r.vout_set != 16'h0000 |->
    s_r.vout_set >= PMC_VOUT_MIN && s_r.vout_set <= PMC_VOUT_MAX)
    else $error("set point out of range");

  AST_MARGIN_HIGH: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    s_r.op[5:2] == PMC_MRG_HIGH ##1 s_r.op[5:2] == PMC_MRG_HIGH |->
    vout_target_o == $past(s_r.mrg_high))
    else $error("margin high not applied");

  AST_STORE_IMAGE: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    seq_store_req |=> nvm_store_o &&
    nvm_image_o[15:0] == $past(s_r.mrg_low) ##1 nvm_store_o ==
    $past(req_valid_i && req_write_i && req_code_i == PMC_CMD_STORE_DEFAULTS))
    else $error("store image wrong");

  AST_SINK_ZERO: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    iout_adc_i[10] |=> s_r.rd_iout == {PMC_EXP_M4, 11'h000})
    else $error("sinking current not zero");

  AST_CFG_RO_BITS: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    req_valid_i && !req_write_i && s_r.st == PMC_ST_RUN &&
    req_code_i == PMC_CMD_ON_OFF_CFG |=> resp_rdata_o[4:0] ==
    {1'b1, $past(s_r.cfg), 2'h3})
    else $error("config read-only bits wrong");

endmodule : pmc_cmd_core

`default_nettype wire

// ===== verif/pmc_host_model.sv
// Host controller model issuing one command request at a time
`timescale 1ns/10ps
`default_nettype none
module pmc_host_model (
  input wire logic clk_i,
  output logic req_valid_o,
  output logic req_write_o,
  output logic [7:0] req_code_o,
  output logic [15:0] req_wdata_o,
  input wire logic resp_valid_i,
  input wire logic [15:0] resp_rdata_i,
  input wire logic resp_bad_cmd_i,
  input wire logic resp_bad_data_i
);
  ////////////////////////////////////////
  // Idle cycles after each answer, for a slow host
  int idle_gap = 0;
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_code_o = 8'h00;
    req_wdata_o = 16'h0000;
  end
  ////////////////////////////////////////
  // Hold through taking edge, then scramble released lines
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [15:0] data, output logic [15:0] rd,
                      output logic [1:0] bad);
    int n;
    @(negedge clk_i);
    req_valid_o = 1'b1;
    req_write_o = wr;
    req_code_o = code;
    req_wdata_o = data;
    @(negedge clk_i);
    req_valid_o = 1'b0;
    req_write_o = ~wr;
    req_code_o = ~code;
    req_wdata_o = ~data;
    n = 0;
    while (resp_valid_i !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    rd = (n < 4) ? resp_rdata_i : 16'hXXXX;
    bad = (n < 4) ? {resp_bad_cmd_i, resp_bad_data_i} : 2'bXX;
    repeat (idle_gap) @(negedge clk_i);
  endtask : xfer
endmodule : pmc_host_model
`default_nettype wire

// ===== verif/pmc_cmd_core_tb_top.sv
// Testbench for the command-value core
`timescale 1ns/10ps
`default_nettype none
module pmc_cmd_core_tb_top;
  import pmc_pkg::*;
  logic ref_clk, rstn, pin, req_valid, req_write, resp_valid;
  logic resp_bad_cmd, resp_bad_data, nvm_store, oe;
  logic [7:0] req_code;
  logic [15:0] req_wdata, resp_rdata, vout_adc, target, rd;
  logic [10:0] vin_adc;
  logic signed [10:0] iout_adc;
  logic [PMC_IMG_W-1:0] img_in, img_out;
  logic [1:0] bad;
  logic [15:0] last [logic [7:0]];
  int comparisons = 0;
  int miscompares = 0;
  int cyc = 0;
  // Code, word, rejected; turn-off kept 2 V below turn-on
  localparam logic [27:0] RANGE_T [23] = '{28'h35E9700, 28'h35E9711,
    28'h35E8FF1, 28'h35ED001, 28'h35F1001, 28'h36E9600, 28'h36E9711,
    28'h60F8140, 28'h60F8131, 28'h60FBE80, 28'h60FBE91, 28'h61F81E0,
    28'h61F81D1, 28'h61FBE80, 28'h21819A0, 28'h2181991, 28'h21D3341,
    28'h21D3330, 28'h21C0000, 28'h25D3341, 28'h25D3330, 28'h26819A0,
    28'h2681991};
  // Operation byte, rejected, target
  localparam logic [27:0] MARGIN_T [5] = '{28'h980819A, 28'hA80D333,
    28'h901D333, 28'h840C000, 28'hBC1C000};
  // Raw current, reading
  localparam logic [27:0] IOUT_T [4] = '{28'h064E092, 28'h016E01D,
    28'h00AE000, 28'h7CEE000};
  // Code, reading
  localparam logic [23:0] READ_T [7] = '{24'h8BBFF0, 24'h88EA48,
    24'hD4FFF0, 24'hD5E808, 24'hD64000, 24'hD7E7FC, 24'hD83000};

  pmc_cmd_core #(
    .VOUT_OFFSET_TRIM(16'hFFF0),
    .VIN_OFFSET_TRIM(11'h008),
    .VIN_GAIN_TRIM(16'h4000),
    .IOUT_OFFSET_TRIM(11'h7FC),
    .IOUT_GAIN_TRIM(16'h3000)
  ) dut (
    .ref_clk_i(ref_clk), .rstn_i(rstn), .req_valid_i(req_valid),
    .req_write_i(req_write), .req_code_i(req_code),
    .req_wdata_i(req_wdata), .resp_valid_o(resp_valid),
    .resp_rdata_o(resp_rdata), .resp_bad_cmd_o(resp_bad_cmd),
    .resp_bad_data_o(resp_bad_data), .onoff_pin_i(pin),
    .vout_adc_i(vout_adc), .vin_adc_i(vin_adc), .iout_adc_i(iout_adc),
    .nvm_image_i(img_in), .nvm_store_o(nvm_store),
    .nvm_image_o(img_out), .output_enable_o(oe), .vout_target_o(target)
  );

  pmc_host_model host (
    .clk_i(ref_clk), .req_valid_o(req_valid), .req_write_o(req_write),
    .req_code_o(req_code), .req_wdata_o(req_wdata),
    .resp_valid_i(resp_valid), .resp_rdata_i(resp_rdata),
    .resp_bad_cmd_i(resp_bad_cmd), .resp_bad_data_i(resp_bad_data)
  );

  ////////////////////////////////////////
  // Clock, timeout and common tasks
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input logic [15:0] d,
                    input logic [1:0] eb);
    host.xfer(1'b1, c, d, rd, bad);
    chk("write flags", {14'h0000, bad}, {14'h0000, eb});
  endtask : wr
  task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
    host.xfer(1'b0, c, 16'h0000, rd, bad);
    chk("read data", rd, e);
  endtask : rdchk
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////
  // Scenarios
  task automatic t_reset_load();
    repeat (11) @(negedge ref_clk);
    chk("enable in reset", {15'h0000, oe}, 16'h0000);
    chk("target in reset", target, 16'h0000);
    @(negedge ref_clk);
    rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("loaded target", target, 16'hC000);
    chk("loaded enable", {15'h0000, oe}, 16'h0001);
    for (int i = 0; i < 7; i++) last[RANGE_T[i * 3][27:20]] = 16'h0000;
    last[8'h35] = 16'hE920;
    last[8'h36] = 16'hE910;
    last[8'h60] = 16'hF828;
    last[8'h61] = 16'hF83C;
    last[8'h21] = 16'hC000;
    last[8'h25] = 16'hC800;
    last[8'h26] = 16'hB800;
  endtask : t_reset_load
  task automatic t_ranges();
    logic [7:0] c;
    logic [15:0] d;
    for (int i = 0; i < 23; i++) begin
      c = RANGE_T[i][27:20];
      d = RANGE_T[i][19:4];
      wr(c, d, {1'b0, RANGE_T[i][0]});
      if (RANGE_T[i][0] == 1'b0) last[c] = d;
      rdchk(c, last[c]);
    end
  endtask : t_ranges
  task automatic t_margin();
    for (int i = 0; i < 5; i++) begin
      wr(PMC_CMD_OPERATION, {8'h00, MARGIN_T[i][27:20]},
         {1'b0, MARGIN_T[i][16]});
      repeat (2) @(negedge ref_clk);
      chk("target", target, MARGIN_T[i][15:0]);
    end
    rdchk(PMC_CMD_OPERATION, 16'h0084);
  endtask : t_margin
  task automatic t_cfg();
    logic [1:0] c;
    logic e;
    host.idle_gap = 2;
    rdchk(PMC_CMD_ON_OFF_CFG, 16'h001F);
    for (int i = 0; i < 16; i++) begin
      c = i[3:2];
      e = i[1];
      wr(PMC_CMD_ON_OFF_CFG, {12'h000, c, 2'b00}, 2'b00);
      rdchk(PMC_CMD_ON_OFF_CFG, {11'h000, 1'b1, c, 2'b11});
      wr(PMC_CMD_OPERATION, {8'h00, e, 7'h00}, 2'b00);
      pin = i[0];
      repeat (3) @(negedge ref_clk);
      chk("enable", {15'h0000, oe},
          {15'h0000, (~c[1] | e) & (~c[0] | i[0])});
    end
    wr(PMC_CMD_ON_OFF_CFG, 16'h000C, 2'b00);
    wr(PMC_CMD_OPERATION, 16'h0080, 2'b00);
    pin = 1'b1;
    host.idle_gap = 0;
  endtask : t_cfg
  task automatic t_store();
    logic [111:0] ei;
    wr(PMC_CMD_VOUT_SET, 16'hB000, 2'b00);
    last[PMC_CMD_VOUT_SET] = 16'hB000;
    wr(PMC_CMD_STORE_DEFAULTS, 16'h0000, 2'b00);
    chk("store pulse", {15'h0000, nvm_store}, 16'h0001);
    ei = {last[8'h35], last[8'h36], last[8'h60], last[8'h61],
          last[8'h21], last[8'h25], last[8'h26]};
    for (int i = 0; i < 7; i++) begin
      chk("image", img_out[i*16 +: 16], ei[i*16 +: 16]);
    end
    wr(PMC_CMD_VOUT_SET, 16'hC000, 2'b00);
    chk("store idle", {15'h0000, nvm_store}, 16'h0000);
    chk("image kept", img_out[47:32], 16'hB000);
  endtask : t_store
  task automatic t_read();
    for (int i = 0; i < 4; i++) begin
      iout_adc = IOUT_T[i][26:16];
      repeat (3) @(negedge ref_clk);
      rdchk(PMC_CMD_MEAS_OUT_I, IOUT_T[i][15:0]);
    end
    for (int i = 0; i < 7; i++) begin
      rdchk(READ_T[i][23:16], READ_T[i][15:0]);
    end
    wr(PMC_CMD_MEAS_OUT_V, 16'h0000, 2'b10);
    wr(8'hFF, 16'h0000, 2'b10);
  endtask : t_read

  ////////////////////////////////////////
  // Main sequence
  initial begin
    rstn = 1'b0;
    pin = 1'b1;
    vout_adc = 16'hC000;
    vin_adc = 11'h120;
    iout_adc = 11'h064;
    img_in = {16'hE920, 16'hE910, 16'hF828, 16'hF83C,
              16'hC000, 16'hC800, 16'hB800};
    t_reset_load();
    t_ranges();
    t_margin();
    t_cfg();
    t_store();
    t_read();
    results();
  end
endmodule : pmc_cmd_core_tb_top
`default_nettype wire
